//--- logic/abrw_fifo.sv
`timescale 1ns/100ps
module abrw_fifo
	import abrw_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	abrw_stream_if.sink s_in,
	abrw_stream_if.source s_out
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
	localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [WIDTH-1:0] nxt_mem [DEPTH];
	logic [PW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
	logic [PW:0] count_ff, nxt_count;
	logic in_ready_ff, nxt_in_ready;
	logic push, pop;

	assign s_in.ready = in_ready_ff;
	assign s_out.valid = (count_ff != '0);
	assign s_out.data = mem_ff[rd_ptr_ff];

	always_comb begin
		push = s_in.valid & in_ready_ff;
		pop = s_out.valid & s_out.ready;
		nxt_mem = mem_ff;
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		nxt_count = count_ff;
		if (push) begin
			nxt_mem[wr_ptr_ff] = s_in.data;
			nxt_wr_ptr = (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + 1'b1;
		end
		if (pop) begin
			nxt_rd_ptr = (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + 1'b1;
		end
		case ({push, pop})
			2'h2: nxt_count = count_ff + 1'b1;
			2'h1: nxt_count = count_ff - 1'b1;
			default: nxt_count = count_ff;
		endcase
		// Ready is registered so the source sees a clean flop
		nxt_in_ready = (nxt_count != CNT_FULL);
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			in_ready_ff <= 1'b1;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff <= nxt_count;
			in_ready_ff <= nxt_in_ready;
		end
	end

	// Storage needs no reset; count guards every read
	always_ff @(posedge i_ref_clk) begin
		mem_ff <= nxt_mem;
	end
endmodule : abrw_fifo

//--- logic/abrw_master.sv
`timescale 1ns/100ps
module abrw_master
	import abrw_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic i_req_first,
	input wire logic [FC_W-1:0] i_req_fc,
	input wire logic [SIZE_W-1:0] i_req_size,
	input wire logic [ADDR_W-1:0] i_req_addr,
	input wire logic [DATA_W-1:0] i_req_wdata,
	output logic o_req_ready,
	output logic o_rsp_valid,
	output logic o_rsp_write,
	output logic [DATA_W-1:0] o_rsp_data,
	output logic [1:0] o_rsp_port_code,
	output logic [ADDR_W-1:0] o_addr,
	output logic [FC_W-1:0] o_space_function_code,
	output logic o_transfer_size_hi,
	output logic o_transfer_size_lo,
	output logic o_read_write,
	output logic o_external_cycle_start_n,
	output logic o_operand_cycle_start_n,
	output logic o_address_strobe_n,
	output logic o_data_strobe_n,
	output logic o_data_buffer_enable_n,
	output logic [DATA_W-1:0] o_data,
	output logic o_data_oe_n,
	input wire logic [DATA_W-1:0] i_data,
	input wire logic i_xfer_ack_hi_n,
	input wire logic i_xfer_ack_lo_n,
	output logic o_busy
);
	function automatic abrw_ctl_type ctl_of(input abrw_state_type st, input logic wr,
		input logic first);
		abrw_ctl_type c;
		c = '0;
		case (st)
			ST_S0: begin
				c.external_cycle_start = 1'b1; // RULE_01
				c.operand_cycle_start = first; // RULE_01 RULE_13
			end
			ST_S1: begin
				c.as = 1'b1; // RULE_03 RULE_14
				c.ds = ~wr; // RULE_03
				c.data_buffer_enable = wr; // RULE_14
			end
			ST_S2: begin
				c.as = 1'b1;
				c.ds = ~wr;
				c.data_buffer_enable = 1'b1; // RULE_04
				c.drive = wr; // RULE_15
			end
			ST_S3, ST_WA, ST_WB, ST_S4: begin
				c.as = 1'b1;
				c.ds = 1'b1; // RULE_16
				c.data_buffer_enable = 1'b1; // RULE_18
				c.drive = wr;
			end
			ST_S5: begin
				c.data_buffer_enable = wr; // RULE_11 RULE_19
				c.drive = wr; // RULE_19
			end
			default: begin
				c = '0;
			end
		endcase
		return c;
	endfunction : ctl_of

	// Bus state tick: each bus state lasts STATE_CYCLES reference clocks
	logic [TICK_W-1:0] tick_cnt_ff, nxt_tick_cnt;
	logic tick_ff, nxt_tick;

	always_comb begin
		if (tick_cnt_ff == TICK_LAST) begin
			nxt_tick_cnt = '0;
			nxt_tick = 1'b1;
		end else begin
			nxt_tick_cnt = tick_cnt_ff + 1'b1;
			nxt_tick = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			tick_cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			tick_cnt_ff <= nxt_tick_cnt;
			tick_ff <= nxt_tick;
		end
	end

	// Pin synchronisers; only the second stage is ever looked at
	logic [1:0] ack_meta_ff, ack_sync_ff, nxt_ack_meta, nxt_ack_sync;
	logic [DATA_W-1:0] din_meta_ff, din_sync_ff, nxt_din_meta, nxt_din_sync;

	always_comb begin
		nxt_ack_meta = {~i_xfer_ack_hi_n, ~i_xfer_ack_lo_n}; // RULE_22
		nxt_ack_sync = ack_meta_ff;
		nxt_din_meta = i_data;
		nxt_din_sync = din_meta_ff;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			ack_meta_ff <= 2'h0;
			ack_sync_ff <= 2'h0;
			din_meta_ff <= RST_DATA;
			din_sync_ff <= RST_DATA;
		end else begin
			ack_meta_ff <= nxt_ack_meta;
			ack_sync_ff <= nxt_ack_sync;
			din_meta_ff <= nxt_din_meta;
			din_sync_ff <= nxt_din_sync;
		end
	end

	// Request queue ahead of the bus engine
	abrw_stream_if #(.WIDTH(REQ_W)) req_in ();
	abrw_stream_if #(.WIDTH(REQ_W)) req_out ();
	abrw_req_type in_req;
	logic pop;

	always_comb begin
		in_req.write = i_req_write;
		in_req.first = i_req_first;
		in_req.fc = i_req_fc;
		in_req.size = i_req_size;
		in_req.addr = i_req_addr;
		in_req.wdata = i_req_wdata;
	end

	assign req_in.valid = i_req_valid;
	assign req_in.data = in_req;
	assign o_req_ready = req_in.ready;
	assign req_out.ready = pop;

	abrw_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_req_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.s_in(req_in),
		.s_out(req_out)
	);

	// Bus cycle sequencer
	abrw_state_type state_ff, nxt_state;
	abrw_req_type req_ff, nxt_req;
	logic [1:0] code_ff, nxt_code;
	logic rsp_valid_ff, nxt_rsp_valid;
	logic rsp_write_ff, nxt_rsp_write;
	logic [DATA_W-1:0] rsp_data_ff, nxt_rsp_data;
	logic ack_seen;

	always_comb begin
		nxt_state = state_ff;
		nxt_req = req_ff;
		nxt_code = code_ff;
		nxt_rsp_valid = 1'b0;
		nxt_rsp_write = rsp_write_ff;
		nxt_rsp_data = rsp_data_ff;
		pop = 1'b0;
		// Either line alone is a recognised acknowledge
		ack_seen = |ack_sync_ff; // RULE_22
		if (tick_ff) begin
			case (state_ff)
				ST_IDLE: begin
					if (req_out.valid) begin
						pop = 1'b1;
						nxt_req = req_out.data;
						nxt_state = ST_S0;
					end
				end
				ST_S0: begin
					nxt_state = ST_S1;
				end
				ST_S1: begin
					nxt_state = ST_S2;
				end
				// End of S2 and of each wait pair are falling bus edges
				ST_S2, ST_WB: begin
					if (ack_seen) begin
						nxt_code = ack_sync_ff; // RULE_21
						nxt_state = ST_S3; // RULE_06 RULE_16
					end else begin
						nxt_state = ST_WA; // RULE_07 RULE_08 RULE_09
					end
				end
				ST_WA: begin
					nxt_state = ST_WB; // RULE_09
				end
				ST_S3: begin
					nxt_state = ST_S4;
				end
				ST_S4: begin
					nxt_rsp_valid = 1'b1;
					nxt_rsp_write = req_ff.write;
					// Read data is taken as the slave drives it, RULE_05 on its side
					nxt_rsp_data = req_ff.write ? RST_DATA : din_sync_ff; // RULE_10
					nxt_state = ST_S5;
				end
				ST_S5: begin
					// Next cycle relies on the slave releasing its acknowledge
					if (req_out.valid) begin // RULE_12 RULE_20
						pop = 1'b1;
						nxt_req = req_out.data;
						nxt_state = ST_S0;
					end else begin
						nxt_state = ST_IDLE;
					end
				end
				default: begin
					nxt_state = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state_ff <= ST_IDLE;
			req_ff <= '0;
			code_ff <= RST_PORT_CODE;
			rsp_valid_ff <= 1'b0;
			rsp_write_ff <= 1'b0;
			rsp_data_ff <= RST_DATA;
		end else begin
			state_ff <= nxt_state;
			req_ff <= nxt_req;
			code_ff <= nxt_code;
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_write_ff <= nxt_rsp_write;
			rsp_data_ff <= nxt_rsp_data;
		end
	end

	// Pin drivers, registered from the next state so pins change with the state
	abrw_ctl_type ctl;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [FC_W-1:0] fc_ff, nxt_fc;
	logic [SIZE_W-1:0] size_ff, nxt_size;
	logic rw_ff, nxt_rw;
	logic ecs_n_ff, nxt_ecs_n, ocs_n_ff, nxt_ocs_n;
	logic as_n_ff, nxt_as_n, ds_n_ff, nxt_ds_n;
	logic data_buffer_enable_n_ff, nxt_data_buffer_enable_n;
	logic [DATA_W-1:0] dout_ff, nxt_dout;
	logic doe_n_ff, nxt_doe_n;
	logic busy_ff, nxt_busy;

	always_comb begin
		ctl = ctl_of(nxt_state, nxt_req.write, nxt_req.first);
		// Qualifiers follow the held request, so they stay valid through S5
		nxt_addr = FULL_ADDR_VARIANT ? nxt_req.addr : (nxt_req.addr & EMB_ADDR_MASK); // RULE_02
		nxt_fc = nxt_req.fc; // RULE_02 RULE_13
		nxt_size = nxt_req.size; // RULE_02 RULE_13
		nxt_rw = ~nxt_req.write; // RULE_02 RULE_13 RULE_11
		// The embedded variant has no cycle start or buffer enable pins
		nxt_ecs_n = ~(ctl.external_cycle_start & FULL_ADDR_VARIANT); // RULE_03
		nxt_ocs_n = ~(ctl.operand_cycle_start & FULL_ADDR_VARIANT); // RULE_03 RULE_14
		nxt_as_n = ~ctl.as; // RULE_11 RULE_19
		nxt_ds_n = ~ctl.ds; // RULE_11 RULE_19
		nxt_data_buffer_enable_n = ~(ctl.data_buffer_enable & FULL_ADDR_VARIANT); // RULE_02 RULE_04
		nxt_dout = ctl.drive ? nxt_req.wdata : dout_ff; // RULE_15 RULE_19
		nxt_doe_n = ~ctl.drive;
		nxt_busy = (nxt_state != ST_IDLE);
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			addr_ff <= RST_ADDR;
			fc_ff <= '0;
			size_ff <= '0;
			rw_ff <= 1'b1;
			ecs_n_ff <= 1'b1;
			ocs_n_ff <= 1'b1;
			as_n_ff <= 1'b1;
			ds_n_ff <= 1'b1;
			data_buffer_enable_n_ff <= 1'b1;
			dout_ff <= RST_DATA;
			doe_n_ff <= 1'b1;
			busy_ff <= 1'b0;
		end else begin
			addr_ff <= nxt_addr;
			fc_ff <= nxt_fc;
			size_ff <= nxt_size;
			rw_ff <= nxt_rw;
			ecs_n_ff <= nxt_ecs_n;
			ocs_n_ff <= nxt_ocs_n;
			as_n_ff <= nxt_as_n;
			ds_n_ff <= nxt_ds_n;
			data_buffer_enable_n_ff <= nxt_data_buffer_enable_n;
			dout_ff <= nxt_dout;
			doe_n_ff <= nxt_doe_n;
			busy_ff <= nxt_busy;
		end
	end

	assign o_addr = addr_ff;
	assign o_space_function_code = fc_ff;
	assign o_transfer_size_hi = size_ff[1];
	assign o_transfer_size_lo = size_ff[0];
	assign o_read_write = rw_ff;
	assign o_external_cycle_start_n = ecs_n_ff;
	assign o_operand_cycle_start_n = ocs_n_ff;
	assign o_address_strobe_n = as_n_ff;
	assign o_data_strobe_n = ds_n_ff;
	assign o_data_buffer_enable_n = data_buffer_enable_n_ff;
	assign o_data = dout_ff;
	assign o_data_oe_n = doe_n_ff;
	assign o_busy = busy_ff;
	assign o_rsp_valid = rsp_valid_ff;
	assign o_rsp_write = rsp_write_ff;
	assign o_rsp_data = rsp_data_ff;
	assign o_rsp_port_code = code_ff;
endmodule : abrw_master

//--- logic/abrw_pkg.sv
// Operation
// RULE_01 - Read S0 asserts cycle start; operand start too on an operation's first cycle.
// RULE_02 - Read S0 drives address, space code, size, direction high, buffer enable off.
// RULE_03 - Read S1 asserts address and data strobes, drops both cycle start strobes.
// RULE_04 - Full-address variant asserts data buffer enable during read S2.
// RULE_05 - Slave drives selected byte lanes on reads and returns an acknowledge.
// RULE_06 - Acknowledge seen at end of read S2 ends the cycle with no wait.
// RULE_07 - No acknowledge at start of S3 inserts wait states before S4 and S5.
// RULE_08 - Slave keeps both acknowledges negated around end of S2 to get waits.
// RULE_09 - During waits, acknowledges are sampled again at every falling bus edge.
// RULE_10 - Zero-wait read captures incoming data at the end of S4.
// RULE_11 - Read S5 negates strobes and buffer enable, holds address and qualifiers.
// RULE_12 - Slave holds read data and acknowledge until a strobe drops, then releases.
// RULE_13 - Write S0 drives address, space code, size, direction low, operand start.
// RULE_14 - Write S1 asserts address strobe and buffer enable, drops cycle start strobes.
// RULE_15 - Write S2 drives the full data bus; acknowledges sampled at end of S2.
// RULE_16 - Write S3 asserts data strobe; ends a clock later or waits before S4.
// RULE_17 - Slave latches selected write lanes and acknowledges once data is stored.
// RULE_18 - No control line changes during write S4.
// RULE_19 - Write S5 drops strobes, holds address, data, qualifiers and buffer enable.
// RULE_20 - Slave holds write acknowledge until a strobe drops, then releases it.
// RULE_21 - Slave acknowledge combination encodes its port width.
// RULE_22 - Acknowledges are synchronised and judged only at falling bus clock edges.
package abrw_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int FC_W = 3;
	localparam int SIZE_W = 2;
	localparam int FIFO_DEPTH = 4;
	localparam int REF_CLK_MHZ = 100;
	localparam int REF_CLK_PERIOD_NS = 10;
	// Each bus state lasts half a bus clock
	localparam int BUS_HALF_CLK_NS = 20;
	localparam int STATE_CYCLES_RAW = (BUS_HALF_CLK_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
	localparam int STATE_CYCLES = (STATE_CYCLES_RAW < 1) ? 1 : STATE_CYCLES_RAW;
	localparam int TICK_W = 4;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(STATE_CYCLES - 1);
	localparam bit FULL_ADDR_VARIANT = 1'b1;
	localparam logic [ADDR_W-1:0] EMB_ADDR_MASK = 32'h00FF_FFFF;
	localparam logic [ADDR_W-1:0] RST_ADDR = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;
	localparam logic [1:0] RST_PORT_CODE = 2'h0;

	typedef struct packed {
		logic write;
		logic first;
		logic [FC_W-1:0] fc;
		logic [SIZE_W-1:0] size;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} abrw_req_type;
	localparam int REQ_W = $bits(abrw_req_type);

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_S0 = 9'h002,
		ST_S1 = 9'h004,
		ST_S2 = 9'h008,
		ST_WA = 9'h010,
		ST_WB = 9'h020,
		ST_S3 = 9'h040,
		ST_S4 = 9'h080,
		ST_S5 = 9'h100
	} abrw_state_type;

	typedef struct packed {
		logic external_cycle_start;
		logic operand_cycle_start;
		logic as;
		logic ds;
		logic data_buffer_enable;
		logic drive;
	} abrw_ctl_type;
endpackage : abrw_pkg

//--- logic/abrw_stream_if.sv
`timescale 1ns/100ps
interface abrw_stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport source(output valid, output data, input ready);
	modport sink(input valid, input data, output ready);
endinterface : abrw_stream_if

//--- tb/abrw_checker.sv
`timescale 1ns/100ps
module abrw_checker
	import abrw_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_xfer_ack_hi_n,
	input wire logic i_xfer_ack_lo_n,
	input wire logic o_rsp_valid,
	input wire logic o_rsp_write,
	input wire logic [ADDR_W-1:0] o_addr,
	input wire logic [FC_W-1:0] o_space_function_code,
	input wire logic o_transfer_size_hi,
	input wire logic o_transfer_size_lo,
	input wire logic o_read_write,
	input wire logic o_external_cycle_start_n,
	input wire logic o_operand_cycle_start_n,
	input wire logic o_address_strobe_n,
	input wire logic o_data_strobe_n,
	input wire logic o_data_buffer_enable_n,
	input wire logic [DATA_W-1:0] o_data,
	input wire logic o_data_oe_n
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	logic [6:0] ctl;
	logic [ADDR_W+FC_W+2:0] qual;
	assign ctl = {o_external_cycle_start_n, o_operand_cycle_start_n, o_address_strobe_n,
		o_data_strobe_n, o_data_buffer_enable_n, o_data_oe_n, o_read_write};
	assign qual = {o_addr, o_space_function_code, o_transfer_size_hi, o_transfer_size_lo,
		o_read_write};
	// Every bus state lasts two reference clocks, so S0 shows for two samples
	sequence s_start;
		!o_external_cycle_start_n [*2] ##1 o_external_cycle_start_n && !o_address_strobe_n;
	endsequence
	a_cycle_start: assert property ($fell(o_external_cycle_start_n) |-> o_address_strobe_n &&
		(o_data_buffer_enable_n || !o_read_write) ##0 s_start) else $error("bad cycle start");
	a_operand_start: assert property ($fell(o_operand_cycle_start_n) |->
		$fell(o_external_cycle_start_n)) else $error("operand start alone");
	a_read_strobes: assert property ($fell(o_address_strobe_n) && o_read_write |->
		!o_data_strobe_n && o_data_buffer_enable_n [*2] ##1 !o_data_buffer_enable_n)
		else $error("read strobe order");
	a_write_strobes: assert property ($fell(o_address_strobe_n) && !o_read_write |->
		!o_data_buffer_enable_n ##0 o_data_strobe_n [*4] ##1 !o_data_strobe_n)
		else $error("write strobe order");
	a_write_data_on: assert property ($fell(o_data_strobe_n) && !o_read_write |->
		!o_data_oe_n && !$past(o_data_oe_n, 2)) else $error("write data late");
	a_end_strobes: assert property ($rose(o_address_strobe_n) |-> o_data_strobe_n &&
		o_rsp_valid && (o_data_buffer_enable_n || !o_read_write)) else $error("bad end");
	a_hold_qual: assert property ($rose(o_address_strobe_n) |->
		$stable(qual) ##1 $stable(qual)) else $error("qualifiers moved in S5");
	a_write_hold: assert property ($rose(o_address_strobe_n) && !o_read_write |->
		$stable(o_data) && !o_data_oe_n && !o_data_buffer_enable_n) else $error("write hold");
	a_write_s4_quiet: assert property (o_rsp_valid && o_rsp_write |->
		$past(ctl, 1) == $past(ctl, 2) && $past(ctl, 2) == $past(ctl, 3))
		else $error("control moved in S4");
	a_no_ack_wait: assert property ((i_xfer_ack_hi_n && i_xfer_ack_lo_n) [*8] |->
		!o_rsp_valid) else $error("cycle ended without ack");
	a_ack_ends: assert property ($fell(i_xfer_ack_hi_n && i_xfer_ack_lo_n) &&
		!o_address_strobe_n |-> ##[1:16] o_rsp_valid) else $error("ack not seen");
endmodule : abrw_checker

bind abrw_master abrw_checker i_chk (.i_ref_clk, .i_rst_n, .i_xfer_ack_hi_n, .i_xfer_ack_lo_n,
	.o_rsp_valid, .o_rsp_write, .o_addr, .o_space_function_code, .o_transfer_size_hi,
	.o_transfer_size_lo, .o_read_write, .o_external_cycle_start_n, .o_operand_cycle_start_n,
	.o_address_strobe_n, .o_data_strobe_n, .o_data_buffer_enable_n, .o_data, .o_data_oe_n);

//--- tb/abrw_slave.sv
`timescale 1ns/100ps
module abrw_slave
	import abrw_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_address_strobe_n,
	input wire logic i_data_strobe_n,
	input wire logic i_read_write,
	input wire logic [DATA_W-1:0] i_data,
	input wire logic [3:0] i_delay,
	input wire logic [1:0] i_port_code,
	output logic o_xfer_ack_hi_n,
	output logic o_xfer_ack_lo_n,
	output logic [DATA_W-1:0] o_data,
	output logic [DATA_W-1:0] o_mem
);
	logic [3:0] wait_ff;
	logic ack_ff;
	// Acknowledge lines are driven high whenever not asserted, so a released line reads high
	assign o_xfer_ack_hi_n = !(ack_ff && i_port_code[1]);
	assign o_xfer_ack_lo_n = !(ack_ff && i_port_code[0]);
	always @(posedge i_ref_clk) begin
		if (!i_rst_n || i_address_strobe_n) begin
			wait_ff <= 4'h0;
			ack_ff <= 1'b0;
		end else if (wait_ff != i_delay) begin
			wait_ff <= wait_ff + 4'h1;
		end else begin
			ack_ff <= 1'b1;
		end
		if (!i_rst_n)
			o_mem <= 32'h0000_0000;
		else if (!i_address_strobe_n && !i_data_strobe_n && !i_read_write)
			o_mem <= i_data;
		// A released bus toggles so that stale data can never pass as a read
		if (!i_rst_n)
			o_data <= 32'h0000_0000;
		else
			o_data <= (ack_ff && i_read_write && !i_address_strobe_n) ? o_mem : ~o_data;
	end
endmodule : abrw_slave

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
	import abrw_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic req_first = 1'b0;
	logic [2:0] req_fc = 3'h0;
	logic [1:0] req_size = 2'h0;
	logic [31:0] req_addr = 32'h0000_0000;
	logic [31:0] req_wdata = 32'h0000_0000;
	logic [3:0] dly = 4'h0;
	logic [1:0] code = 2'h3;
	logic req_ready, rsp_valid, rsp_write, size_hi, size_lo, rw, ecs_n, ocs_n, as_n, ds_n;
	logic data_buffer_enable_n, oe_n, ack_hi_n, ack_lo_n, busy;
	logic [1:0] rsp_code;
	logic [2:0] fc;
	logic [31:0] rsp_data, addr, m_data, sl_data, sl_mem, bus;
	int n_errors = 0;
	int n_tests = 0;
	int n_cyc = 0;
	// The master owns the data bus only while its enable is low
	assign bus = oe_n ? sl_data : m_data;
	always #5 ref_clk = ~ref_clk;

	abrw_master i_dut (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_req_valid(req_valid),
		.i_req_write(req_write), .i_req_first(req_first), .i_req_fc(req_fc),
		.i_req_size(req_size), .i_req_addr(req_addr), .i_req_wdata(req_wdata),
		.o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_write(rsp_write),
		.o_rsp_data(rsp_data), .o_rsp_port_code(rsp_code), .o_addr(addr),
		.o_space_function_code(fc), .o_transfer_size_hi(size_hi), .o_transfer_size_lo(size_lo),
		.o_read_write(rw), .o_external_cycle_start_n(ecs_n), .o_operand_cycle_start_n(ocs_n),
		.o_address_strobe_n(as_n), .o_data_strobe_n(ds_n), .o_data_buffer_enable_n(data_buffer_enable_n),
		.o_data(m_data), .o_data_oe_n(oe_n), .i_data(bus), .i_xfer_ack_hi_n(ack_hi_n),
		.i_xfer_ack_lo_n(ack_lo_n), .o_busy(busy));
	abrw_slave i_slave (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_address_strobe_n(as_n),
		.i_data_strobe_n(ds_n), .i_read_write(rw), .i_data(bus), .i_delay(dly),
		.i_port_code(code), .o_xfer_ack_hi_n(ack_hi_n), .o_xfer_ack_lo_n(ack_lo_n),
		.o_data(sl_data), .o_mem(sl_mem));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	always @(posedge ref_clk) begin
		n_cyc++;
		if (n_cyc == 5000) begin
			n_errors++;
			summarize();
		end
	end

	// One bus cycle with latency measured from address strobe to the response
	task automatic cyc(input logic w, input logic f, input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] dl, input logic [31:0] exp_rd);
		int n;
		logic ocs_seen;
		@(negedge ref_clk);
		dly = dl;
		{req_valid, req_write, req_first, req_addr, req_wdata} = {1'b1, w, f, a, d};
		{req_fc, req_size} = {a[6:4], a[1:0]};
		@(negedge ref_clk);
		req_valid = 1'b0;
		n = 0;
		ocs_seen = 1'b0;
		while (as_n !== 1'b0 && n < 40) begin
			ocs_seen |= !ocs_n;
			@(negedge ref_clk);
			n++;
		end
		check("address", addr, a);
		check("qualifiers", {fc, size_hi, size_lo, rw}, {a[6:4], a[1:0], !w});
		check("operand start", ocs_seen, f);
		n = 0;
		while (rsp_valid !== 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		if (dl == 4'h0)
			check("zero wait latency", n, 8);
		else
			check("wait latency", n > 8 && (n - 8) % 4 == 0, 1);
		check("rsp kind", rsp_write, w);
		check("rsp data", rsp_data, w ? 32'h0000_0000 : exp_rd);
		check("port code", rsp_code, code);
		if (w)
			check("stored", sl_mem, d);
		n = 0;
		while (busy !== 1'b0 && n < 20) begin
			@(negedge ref_clk);
			n++;
		end
	endtask : cyc

	task automatic t_reset;
		check("idle pins", {ecs_n, ocs_n, as_n, ds_n, data_buffer_enable_n, oe_n}, 6'h3F);
		check("idle state", {rw, req_ready, rsp_valid, busy}, 4'hC);
		$display("test reset done");
	endtask : t_reset

	task automatic t_zero_wait;
		for (int i = 1; i < 4; i++) begin
			code = i[1:0];
			cyc(1'b1, i[0], 32'h0000_0050 + i, 32'hA5C3_0F00 + i, 4'h0, 32'h0);
			cyc(1'b0, !i[0], 32'h0000_0020 + i, 32'h0, 4'h0, 32'hA5C3_0F00 + i);
		end
		$display("test zero_wait done");
	endtask : t_zero_wait

	task automatic t_wait_states;
		cyc(1'b1, 1'b1, 32'h1234_5672, 32'h0BAD_F00D, 4'h5, 32'h0);
		cyc(1'b0, 1'b0, 32'h1234_5671, 32'h0, 4'hD, 32'h0BAD_F00D);
		$display("test wait_states done");
	endtask : t_wait_states

	task automatic t_fifo;
		int n;
		int got;
		@(negedge ref_clk);
		dly = 4'hF;
		{req_valid, req_write, req_wdata} = {2'b11, 32'h0000_0010};
		@(negedge ref_clk);
		req_valid = 1'b0;
		n = 0;
		while (as_n !== 1'b0 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		for (int i = 0; i < 5; i++) begin
			{req_valid, req_wdata} = {1'b1, 32'(i)};
			@(negedge ref_clk);
		end
		check("queue full", req_ready, 1'b0);
		req_valid = 1'b0;
		got = 0;
		n = 0;
		while (got < 5 && n < 600) begin
			@(negedge ref_clk);
			n++;
			if (rsp_valid === 1'b1)
				got++;
		end
		check("drained", got, 5);
		check("last stored", sl_mem, 32'h0000_0003);
		check("queue free", req_ready, 1'b1);
		$display("test fifo done");
	endtask : t_fifo

	initial begin
		repeat (6) @(negedge ref_clk);
		rst_n = 1'b1;
		t_reset();
		t_zero_wait();
		t_wait_states();
		t_fifo();
		summarize();
	end
endmodule : testbench
